// [tcpa_cfg.svh]
/*
  Register offsets, field positions and reset values of the PWM array.
  Assumes inclusion by bare name; holds definitions only.
*/
`ifndef TCPA_CFG_SVH
`define TCPA_CFG_SVH

// ------------------------------------------------------------
// register offsets (word index on the plain register port)
// ------------------------------------------------------------
`define TCPA_A_CTRL   4'h0
`define TCPA_A_PERIOD 4'h1
`define TCPA_A_COUNT  4'h2
`define TCPA_A_STAT   4'h3
`define TCPA_A_CMP0   4'h4
`define TCPA_A_CHCFG  4'h8

// ------------------------------------------------------------
// control and status register fields
// ------------------------------------------------------------
`define TCPA_F_RUN  0
`define TCPA_F_MODE 1
`define TCPA_F_CPRL 3
`define TCPA_F_DOWN_COUNT_ENABLE 4
`define TCPA_F_TPS  5
`define TCPA_F_PHS  9
`define TCPA_F_PHASE_ROTATE_DIRECTION 12
`define TCPA_F_FLAG 0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TCPA_RST_CTRL  16'h0000
`define TCPA_RST_PER   16'hFFFF
`define TCPA_RST_CMP   16'h0000
`define TCPA_RST_CHCFG 16'h0000
`define TCPA_RST_OUT   4'hF

`endif

// [tcpa_load_model.sv]
/*
  Load model on the four PWM pins: counts rising edges on each pin.
  Assumes pins sampled on the block clock and cleared by its reset.
*/
`timescale 1ns/1ps

module tcpa_load_model (
  input  logic        clk,
  input  logic        nrst,
  input  logic [3:0]  pwmChannelOutput,
  output logic [31:0] riseCnt
);
  logic [3:0] last;

  // ----------------------------------------
  // rising edge counter, one byte per pin
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      riseCnt <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pwmChannelOutput[i] && !last[i]) begin
          riseCnt[8*i +: 8] <= riseCnt[8*i +: 8] + 8'h01;
        end
      end
    end
    last <= pwmChannelOutput;
  end
endmodule : tcpa_load_model

// [tcpa_pkg.sv]
/*
  Types shared by the PWM array: bus request carrier, modes, direction.
  Assumes nothing of its surroundings.
*/
package tcpa_pkg;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  // one request on the plain register port
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        we;
    logic        re;
  } tcpa_bus_t;

  // per channel: compare-mode enable and action field
  typedef struct packed {
    logic       cme;
    logic [2:0] act;
  } tcpa_chcfg_t;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } tcpa_dir_t;

  typedef enum logic [1:0] {
    CM_OFF  = 2'b00,
    CM_EDGE = 2'b01,
    CM_PFC  = 2'b10,
    CM_PC   = 2'b11
  } tcpa_cm_t;

  typedef enum logic [2:0] {
    PHS_OFF = 3'h0,
    PHS_2   = 3'h1,
    PHS_3   = 3'h2,
    PHS_4   = 3'h3,
    PHS_24  = 3'h4
  } tcpa_phs_t;

endpackage : tcpa_pkg

// [tcpa_top.sv]
/*
  Four-channel PWM array on a shared 16-bit timer, with period and duty
  shadows, polarity, extreme values and a multi-phasic rotator.
  Assumes one clock, a same-domain register master and tcpa_pkg.
*/
// Implementation choices: the strobed register port and the placing of the registers.
// How it works
// R1: edge mode counts zero up to period, then restarts at zero.
// R2: edge non-inverting: high on compare match, low at wrap.
// R3: edge inverting: low on compare match, high at wrap.
// R4: edge mode period shadow loads only at period-to-zero wrap.
// R5: edge mode duty shadow loads only at the wrap.
// R6: edge period is period plus one ticks; tick is clock over prescale plus one.
// R7: edge: compare at or above period holds inactive, zero holds active.
// R8: center mode counts up to period then down, one tick at period.
// R9: center non-inverting: low on up match, high on down match.
// R10: center inverting: high on up match, low on down match.
// R11: center mode period shadow loads only at underflow.
// R12: center period is twice the period value in ticks.
// R13: center: compare at or above period holds active, zero holds inactive.
// R14: mode 10 loads duty shadows and sets flag only at underflow.
// R15: mode 11 loads duty shadows at underflow and at the top.
// R16: mode 11 sets the overflow flag at underflow and at the top.
// R17: phase field selects off, 1:2, 1:3, 1:4 or 2:4 one-hot rotation.
// R18: a disabled channel behaves as if its compare equals period.
// R19: direction bit reverses the rotation order.
// R20: non-PWM channels keep their rotation slot but are unaffected.
// R21: software changes phase field only while stopped; direction anytime.
// R22: channels outside the rotation run as normal PWM.
// R23: PWM when compare enable is one and action is 10x; bit 0 polarity.
// R24: shadows load on the wrap or turn edge and govern the next count.
// R25: rotator steps each period and restarts at the start of the timer.
`timescale 1ns/1ps
`include "tcpa_cfg.svh"

module tcpa_top (
  input  logic                clk,
  input  logic                nrst,
  input  logic                ce,
  input  tcpa_pkg::tcpa_bus_t bus,
  output logic [15:0]         rdata,
  output logic [3:0]          pwmChannelOutput,
  output logic                timerOverflowFlag
);
  import tcpa_pkg::*;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // last rotator position for a phase mode
  function automatic logic [1:0] lastPos(input logic [2:0] p);
    case (p)
      PHS_2:   lastPos = 2'h1;
      PHS_3:   lastPos = 2'h2;
      PHS_4:   lastPos = 2'h3;
      PHS_24:  lastPos = 2'h1;
      default: lastPos = 2'h0;
    endcase
  endfunction : lastPos

  // channel enables for a phase mode and position
  function automatic logic [3:0] chanMask(input logic [2:0] p, input logic [1:0] q);
    case (p)
      PHS_2:   chanMask = {2'h3, q[0] ? 2'h2 : 2'h1};
      PHS_3:   chanMask = {1'b1, 3'(3'h1 << q)};
      PHS_4:   chanMask = 4'(4'h1 << q);
      PHS_24:  chanMask = q[0] ? 4'hA : 4'h5;
      default: chanMask = 4'hF;
    endcase
  endfunction : chanMask

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [15:0] ctrl;
  logic [15:0] periodReload;
  logic [15:0] cntPer;
  logic [15:0] count;
  logic [15:0] chCfg;
  logic [15:0] cmpReg [4];
  logic [15:0] cmpAct [4];
  logic [3:0]  psc;
  logic [1:0]  pos;
  logic        runQ;
  tcpa_dir_t   dir;

  // ------------------------------------------------------------
  // control decode
  // ------------------------------------------------------------
  logic [1:0]  mode;
  logic [2:0]  phase_mode_select;
  logic        phase_rotate_direction;
  logic        timerOn;
  logic        edgeMode;
  logic        tick;
  logic        start;

  assign mode     = ctrl[`TCPA_F_MODE +: 2];
  assign phase_mode_select      = ctrl[`TCPA_F_PHS +: 3];
  assign phase_rotate_direction     = ctrl[`TCPA_F_PHASE_ROTATE_DIRECTION];
  assign timerOn  = ctrl[`TCPA_F_RUN] && !ctrl[`TCPA_F_CPRL] && !ctrl[`TCPA_F_DOWN_COUNT_ENABLE]
                    && (mode != CM_OFF);
  assign edgeMode = (mode == CM_EDGE);
  assign tick     = ce && timerOn && (psc == ctrl[`TCPA_F_TPS +: 4]); // see R6 see R12
  assign start    = timerOn && !runQ;

  // ------------------------------------------------------------
  // counter next state
  // ------------------------------------------------------------
  logic [15:0] nextCnt;
  tcpa_dir_t   nextDir;
  logic        wrap;
  logic        unf;
  logic        ovf;

  // single slope wraps at period, dual slope turns at period and zero
  always_comb begin
    nextCnt = count;
    nextDir = dir;
    wrap    = 1'b0;
    unf     = 1'b0;
    ovf     = 1'b0;
    if (edgeMode) begin
      if (count >= cntPer) begin // see R1 see R6
        nextCnt = 16'h0000;
        wrap    = 1'b1;
      end else begin
        nextCnt = count + 16'h0001;
      end
    end else if (cntPer == 16'h0000) begin
      unf = 1'b1;
    end else if (dir == DIR_UP && count < cntPer) begin // see R8
      nextCnt = count + 16'h0001;
      ovf     = (nextCnt == cntPer);
    end else begin
      nextCnt = count - 16'h0001; // see R8 see R12
      nextDir = DIR_DOWN;
      if (nextCnt == 16'h0000) begin
        unf     = 1'b1;
        nextDir = DIR_UP;
      end
    end
  end

  // ------------------------------------------------------------
  // shadow loads, flag events, rotator
  // ------------------------------------------------------------
  logic        boundary;
  logic        topLoad;
  logic        loadPer;
  logic        loadCmp;
  logic [15:0] perUse;
  logic [1:0]  lastIdx;
  logic [1:0]  stepPos;
  logic [1:0]  nextPos;
  logic [3:0]  chanOn;

  assign boundary = tick && (edgeMode ? wrap : unf); // see R4 see R11 see R14
  assign topLoad  = tick && ovf && (mode == CM_PC); // see R15 see R16
  assign loadPer  = boundary || !timerOn; // see R24
  assign loadCmp  = loadPer || topLoad; // see R5 see R24
  assign perUse   = loadPer ? periodReload : cntPer;
  assign lastIdx  = lastPos(phase_mode_select);
  assign stepPos  = phase_rotate_direction ? ((pos == 2'h0) ? lastIdx : pos - 2'h1)
                         : ((pos >= lastIdx) ? 2'h0 : pos + 2'h1); // see R19
  assign nextPos  = start ? (phase_rotate_direction ? lastIdx : 2'h0)
                          : (boundary ? stepPos : pos); // see R25
  assign chanOn   = chanMask(phase_mode_select, nextPos); // see R17 see R22

  // ------------------------------------------------------------
  // register port decode
  // ------------------------------------------------------------
  logic        wrCtrl;
  logic        wrPer;
  logic        wrStat;
  logic        wrCfg;
  logic        flagNext;
  logic [15:0] readMux;

  assign wrCtrl   = bus.we && (bus.addr == `TCPA_A_CTRL);
  assign wrPer    = bus.we && (bus.addr == `TCPA_A_PERIOD);
  assign wrStat   = bus.we && (bus.addr == `TCPA_A_STAT);
  assign wrCfg    = bus.we && (bus.addr == `TCPA_A_CHCFG);
  // hardware set wins over a software clear in the same cycle
  assign flagNext = (boundary || topLoad) ? 1'b1 // see R14 see R16
                  : (wrStat && bus.wdata[`TCPA_F_FLAG]) ? 1'b0 : timerOverflowFlag;

  // read selection, unmapped offsets answer zero
  always_comb begin
    case (bus.addr)
      `TCPA_A_CTRL:   readMux = ctrl;
      `TCPA_A_PERIOD: readMux = periodReload;
      `TCPA_A_COUNT:  readMux = count;
      `TCPA_A_STAT:   readMux = {15'h0000, timerOverflowFlag};
      4'h4:           readMux = cmpReg[0];
      4'h5:           readMux = cmpReg[1];
      4'h6:           readMux = cmpReg[2];
      4'h7:           readMux = cmpReg[3];
      `TCPA_A_CHCFG:  readMux = chCfg;
      default:        readMux = 16'h0000;
    endcase
  end

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  logic [3:0]  isPwm;
  logic [3:0]  nonInv;
  logic [3:0]  pinNext;
  logic [15:0] cEff [4];

  for (genvar i = 0; i < 4; i++) begin : g_ch
    tcpa_chcfg_t cfg;
    logic        wrCmp;
    logic [15:0] cUse;
    logic        hit;
    logic        act;

    assign cfg      = chCfg[4*i +: 4];
    assign isPwm[i] = cfg.cme && (cfg.act[2:1] == 2'b10); // see R23 see R20
    assign nonInv[i] = cfg.act[0];
    assign wrCmp    = bus.we && (bus.addr == 4'(`TCPA_A_CMP0 + i));
    assign cUse     = loadCmp ? cmpReg[i] : cmpAct[i]; // see R24
    assign cEff[i]  = chanOn[i] ? cUse : perUse; // see R18

    // act high means the active level: high when non-inverting
    always_comb begin
      hit = 1'b0;
      act = 1'b0;
      if (edgeMode) begin
        if (nextCnt == 16'h0000) begin // see R2 see R3 see R7
          hit = 1'b1;
          act = (cEff[i] == 16'h0000);
        end else if (nextCnt == cEff[i] && cEff[i] < perUse) begin
          hit = 1'b1;
          act = 1'b1;
        end
      end else if (cEff[i] == 16'h0000) begin // see R13
        hit = 1'b1;
      end else if (cEff[i] >= perUse) begin
        hit = 1'b1;
        act = 1'b1;
      end else if (nextCnt == cEff[i]) begin // see R9 see R10
        hit = 1'b1;
        act = (nextDir == DIR_DOWN); // direction after this tick: leaving the top is down
      end
    end

    assign pinNext[i] = (tick && isPwm[i] && hit) ? (act ~^ nonInv[i])
                                                   : pwmChannelOutput[i];

    // compare value and its shadow
    always_ff @(posedge clk) begin
      if (!nrst) begin
        cmpReg[i] <= `TCPA_RST_CMP;
        cmpAct[i] <= `TCPA_RST_CMP;
      end else if (ce) begin
        if (wrCmp) cmpReg[i] <= bus.wdata;
        if (loadCmp) cmpAct[i] <= cmpReg[i]; // see R5 see R14 see R15
      end
    end
  end

  // ------------------------------------------------------------
  // registers written by software
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl              <= `TCPA_RST_CTRL;
      periodReload      <= `TCPA_RST_PER;
      chCfg             <= `TCPA_RST_CHCFG;
      timerOverflowFlag <= 1'b0;
      rdata             <= 16'h0000;
    end else if (ce) begin
      if (wrCtrl) ctrl <= bus.wdata; // see R21
      if (wrPer) periodReload <= bus.wdata;
      if (wrCfg) chCfg <= bus.wdata;
      timerOverflowFlag <= flagNext;
      rdata             <= bus.re ? readMux : 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // timer, prescaler, rotator and outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      count            <= 16'h0000;
      cntPer           <= `TCPA_RST_PER;
      dir              <= DIR_UP;
      psc              <= 4'h0;
      pos              <= 2'h0;
      runQ             <= 1'b0;
      pwmChannelOutput <= `TCPA_RST_OUT;
    end else if (ce) begin
      runQ             <= timerOn;
      pos              <= nextPos;
      pwmChannelOutput <= pinNext;
      psc              <= (tick || !timerOn) ? 4'h0 : psc + 4'h1;
      if (loadPer) cntPer <= periodReload; // see R4 see R11
      if (!timerOn) begin
        count <= 16'h0000;
        dir   <= DIR_UP;
      end else if (tick) begin
        count <= nextCnt;
        dir   <= nextDir;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_EDGE_WRAP: assert property (@(posedge clk) disable iff (!nrst) // see R1
    (tick && edgeMode && count >= cntPer) |=> (count == 16'h0000))
    else $error("edge counter did not wrap to zero");

  AST_CENTER_TOP: assert property (@(posedge clk) disable iff (!nrst) // see R8
    (tick && !edgeMode && timerOn && cntPer > 16'h0001 && count == cntPer)
    |=> (count == $past(count) - 16'h0001) && (dir == DIR_DOWN))
    else $error("center counter did not leave the top after one tick");

  AST_PER_HOLD: assert property (@(posedge clk) disable iff (!nrst) // see R4
    (timerOn && !boundary) |=> $stable(cntPer))
    else $error("period shadow changed between period boundaries");

  AST_CMP_HOLD: assert property (@(posedge clk) disable iff (!nrst) // see R5
    (timerOn && !loadCmp) |=> $stable(cmpAct[0]))
    else $error("duty shadow changed outside a load point");

  AST_PC_FLAG: assert property (@(posedge clk) disable iff (!nrst) // see R16
    (tick && ovf && mode == CM_PC) |=> timerOverflowFlag)
    else $error("overflow flag not set at the top in mode 11");

  AST_PFC_NOFLAG: assert property (@(posedge clk) disable iff (!nrst) // see R14
    (tick && mode == CM_PFC && !unf && !timerOverflowFlag) |=> !timerOverflowFlag)
    else $error("overflow flag set away from underflow in mode 10");

  AST_EDGE_ZERO: assert property (@(posedge clk) disable iff (!nrst) // see R7
    (boundary && edgeMode && isPwm[0] && nonInv[0] && cEff[0] == 16'h0000)
    |=> pwmChannelOutput[0])
    else $error("zero compare did not hold the edge output high");

  AST_CENTER_FULL: assert property (@(posedge clk) disable iff (!nrst) // see R13
    (tick && !edgeMode && isPwm[0] && !nonInv[0] && cEff[0] >= perUse
     && cEff[0] != 16'h0000) |=> !pwmChannelOutput[0])
    else $error("full compare did not hold the inverting center output low");

  AST_ROT_START: assert property (@(posedge clk) disable iff (!nrst) // see R25
    (ce && start && phase_mode_select == PHS_4 && !phase_rotate_direction) |=> (pos == 2'h0))
    else $error("rotator did not restart at channel A");

  AST_ROT_REV: assert property (@(posedge clk) disable iff (!nrst) // see R19
    (ce && start && phase_mode_select == PHS_4 && phase_rotate_direction) |=> (pos == 2'h3))
    else $error("reverse rotator did not restart at channel D");

endmodule : tcpa_top

// [testbench.sv]
/*
  Self-checking bench of tcpa_top with a cycle model of timer and pins.
  Assumes tcpa_pkg, tcpa_cfg.svh and tcpa_load_model compiled first.
*/
`timescale 1ns/1ps
`include "tcpa_cfg.svh"

module testbench;
  import tcpa_pkg::*;
  logic        clk, nrst, ce, flag, rdPend, armed, up, flagM;
  tcpa_bus_t   bus;
  logic [15:0] rdata, ctl, chc, rP, sP, cnt;
  logic [15:0] rC [4];
  logic [15:0] sC [4];
  logic [3:0]  pwm, o;
  logic [31:0] riseCnt;
  logic [63:0] rc;
  logic [15:0] expq [$];
  int          failures, n_tests, pc, pos;

  tcpa_top uut (.clk(clk), .nrst(nrst), .ce(ce), .bus(bus), .rdata(rdata),
                .pwmChannelOutput(pwm), .timerOverflowFlag(flag));
  tcpa_load_model load (.clk(clk), .nrst(nrst), .pwmChannelOutput(pwm), .riseCnt(riseCnt));

  // ----------------------------------------
  // clock, compare, verdict
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d, failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // ----------------------------------------
  // reference model of timer, shadows, rotator
  // ----------------------------------------
  // one-hot rotator enables for a period position
  function automatic logic [3:0] emask(input logic [2:0] m, input logic d, input int p);
    int         n;
    int         k;
    logic [3:0] e;
    if (m == 3'h0 || m > 3'h4) return 4'hF;
    n = (m == 3'h4) ? 2 : int'(m) + 1;
    k = p % n;
    if (d) k = n - 1 - k;
    e = 4'h1 << k;
    if (m == 3'h4) e = e | (e << 2);
    else e = e | (4'hF << n);
    return e;
  endfunction : emask

  // state after one clock edge, given what the edge sampled
  task automatic model(input tcpa_bus_t b);
    logic        tk, wrap, top, h, v;
    logic [15:0] c;
    logic [3:0]  en;
    tk = 1'b0;
    wrap = 1'b0;
    top = 1'b0;
    if (!nrst) begin
      ctl = 16'h0000;
      chc = 16'h0000;
      rP = 16'hFFFF;
      rC = '{default: 16'h0000};
      o = 4'hF;
      armed = 1'b0;
      up = 1'b0;
    end else if (ce) begin
      // timer runs only in auto-reload up counting with a nonzero count mode
      if (ctl[0] && ctl[4:1] inside {[4'h1:4'h3]}) begin
        tk = (pc == int'(ctl[8:5]));
        pc = tk ? 0 : pc + 1;
      end
      if (tk && ctl[2:1] == 2'b01) begin
        wrap = (cnt >= sP);
        cnt = wrap ? 16'h0000 : cnt + 16'h0001;
      end else if (tk && up) begin
        cnt = cnt + 16'h0001;
        top = (cnt == sP);
        up = !top;
      end else if (tk) begin
        cnt = cnt - 16'h0001;
        wrap = (cnt == 16'h0000);
        up = wrap;
      end
      if (b.we && b.addr == `TCPA_A_STAT && b.wdata[0]) flagM = 1'b0;
      if (wrap) begin
        sP = rP;
        sC = rC;
        pos++;
        flagM = 1'b1;
        armed = 1'b1;
      end
      if (top && ctl[2:1] == 2'b11) begin
        sC = rC;
        flagM = 1'b1;
      end
      en = emask(ctl[11:9], ctl[12], pos);
      for (int i = 0; i < 4; i++) begin
        c = en[i] ? sC[i] : sP;
        h = 1'b1;
        if (ctl[2:1] == 2'b01) begin
          if (c == 16'h0000) v = 1'b1;
          else if (c >= sP) v = 1'b0;
          else if (cnt == c) v = 1'b1;
          else if (cnt == 16'h0000) v = 1'b0;
          else h = 1'b0;
        end else begin
          if (c == 16'h0000) v = 1'b0;
          else if (c >= sP) v = 1'b1;
          else if (cnt == c) v = !up;
          else h = 1'b0;
        end
        if (tk && h && chc[4*i+1 +: 3] == 3'b110) o[i] = v ^ !chc[4*i];
      end
      if (b.we) begin
        case (b.addr)
          `TCPA_A_CTRL:   ctl = b.wdata;
          `TCPA_A_PERIOD: rP = b.wdata;
          `TCPA_A_CHCFG:  chc = b.wdata;
          4'h4, 4'h5, 4'h6, 4'h7: rC[b.addr[1:0]] = b.wdata;
          default: ;
        endcase
      end
    end
    if (!nrst) flagM = 1'b0;
    if (!(ctl[0] && ctl[4:1] inside {[4'h1:4'h3]})) begin
      sP = rP;
      sC = rC;
      cnt = 16'h0000;
      up = 1'b1;
      pc = 0;
      pos = 0;
      armed = 1'b0;
    end
  endtask : model

  // ----------------------------------------
  // driver: one task call per clock edge
  // ----------------------------------------
  task automatic step(input tcpa_bus_t b);
    @(posedge clk);
    if (armed) begin
      check({12'h000, pwm}, {12'h000, o});
      check({15'h0000, flag}, {15'h0000, flagM});
    end
    model(bus);
    bus <= b;
  endtask : step

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    step('{a, d, 1'b1, 1'b0});
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    step('{a, 16'h0000, 1'b0, 1'b1});
    expq.push_back(e);
  endtask : rd

  // read data is compared one cycle after the strobe is taken
  always @(posedge clk) begin
    if (rdPend) check(rdata, expq.pop_front());
    rdPend <= bus.re && ce && nrst;
  end

  // one configuration, run for n edges, optional mid-run rewrite
  task automatic scen(input logic [15:0] c0, p, cfg, input logic [63:0] cm,
                      input int n, mid, rnd);
    step('0); // let a pending read be taken before reset
    nrst <= 1'b0;
    step('0);
    nrst <= 1'b1;
    wr(`TCPA_A_PERIOD, p);
    for (int i = 0; i < 4; i++) wr(`TCPA_A_CMP0 + 4'(i), cm[16*i +: 16]);
    wr(`TCPA_A_CHCFG, cfg);
    wr(`TCPA_A_CTRL, c0); // phase field only while stopped
    wr(`TCPA_A_CTRL, c0 | 16'h0001);
    for (int k = 1; k <= n; k++) begin
      if (rnd) ce <= ($urandom % 6) != 0;
      if (k == mid) wr(`TCPA_A_CMP0, cm[15:0] + 16'h0001);
      else if (k == mid + 1) wr(`TCPA_A_PERIOD, p + 16'h0002);
      else step('0);
    end
    ce <= 1'b1;
    wr(`TCPA_A_CTRL, c0);
    step('0);
    rd(`TCPA_A_STAT, {15'h0000, flagM});
    wr(`TCPA_A_STAT, 16'h0001);
    rd(`TCPA_A_STAT, 16'h0000);
  endtask : scen

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    bus = '0;
    nrst = 1'b0;
    ce = 1'b1;
    rdPend = 1'b0;
    armed = 1'b0;
    failures = 0;
    n_tests = 0;
    void'($urandom(32'h165E33B9));
    repeat (6) step('0);
    nrst <= 1'b1;
    rd(`TCPA_A_CTRL, 16'h0000);
    rd(`TCPA_A_PERIOD, 16'hFFFF);
    rd(4'h7, 16'h0000);
    rd(`TCPA_A_CHCFG, 16'h0000);
    wr(`TCPA_A_PERIOD, 16'h1234);
    rd(`TCPA_A_PERIOD, 16'h1234);
    wr(`TCPA_A_COUNT, 16'h5555);
    wr(4'hF, 16'hFFFF);
    rd(`TCPA_A_COUNT, 16'h0000);
    rd(4'hF, 16'h0000);
    scen(16'h0002, 16'h0003, 16'hCDCD, 64'h0003_0000_0002_0001, 40, 9, 0);
    scen(16'h0004, 16'h0004, 16'hCDCD, 64'h0005_0000_0003_0002, 60, 9, 0);
    scen(16'h0006, 16'h0004, 16'hCDCD, 64'h0005_0000_0003_0002, 60, 9, 0);
    scen(16'h0042, 16'h0003, 16'hCDDC, 64'h0001_0002_0001_0002, 60, 0, 0);
    scen(16'h0202, 16'h0003, 16'hDDDD, 64'h0001_0001_0001_0001, 40, 0, 0);
    scen(16'h1402, 16'h0003, 16'hDD0D, 64'h0002_0001_0001_0001, 50, 0, 0);
    check(16'(riseCnt[15:8]), 16'h0000);
    scen(16'h0604, 16'h0003, 16'hDDDD, 64'h0001_0002_0001_0002, 60, 0, 0);
    scen(16'h1802, 16'h0003, 16'hCDCD, 64'h0002_0001_0002_0001, 40, 0, 0);
    scen(16'h1602, 16'h0003, 16'hDDDD, 64'h0001_0002_0001_0002, 40, 0, 0);
    scen(16'h0002, 16'h0003, 16'hCDCD, 64'h0003_0001_0002_0000, 40, 0, 0);
    scen(16'h0004, 16'h0004, 16'hCDCC, 64'h0002_0001_0003_0009, 40, 0, 0);
    scen(16'h0012, 16'h0003, 16'hDDDD, 64'h0001_0001_0001_0001, 20, 0, 0);
    for (int i = 0; i < 4; i++) rc[16*i +: 16] = 16'($urandom_range(8, 1));
    scen(16'h0002, 16'h0009, 16'hCDCD, rc, 80, 0, 1);
    repeat (2) step('0); // last read answered and compared before the verdict
    results();
  end

  initial begin
    #500000;
    failures++;
    results();
  end
endmodule : testbench
